// ==== bus_model.sv ====
// open-drain bus with pull-ups and another party on the far side
// assumes enables high mean a party pulls the line low
`timescale 1ns/10ps
module bus_model (
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic hold_scl,
	input  wire logic hold_sda,
	output logic      scl,
	output logic      sda
);
	// wired-and: any party pulling wins, else pull-up
	assign scl = !(scl_oe || hold_scl);
	assign sda = !(sda_oe || hold_sda);
endmodule

// ==== rstart_brg.sv ====
// reloadable down counter that paces the sequence
// assumes load and run come from the sequencer on the same clock
`timescale 1ns/10ps
module rstart_brg (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          load,
	input  wire logic [rstart_pkg::RATE_W-1:0] value,
	input  wire logic                          run,
	output logic                               done
);
	logic [rstart_pkg::RATE_W-1:0] count;

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= rstart_pkg::RATE_RESET;
		end else if (load) begin
			count <= value;
		end else if (run && count != 7'h00) begin
			count <= count - 7'h01;
		end
	end

	// no load term, so a reload may be decided on done without a loop
	assign done = run && count == 7'h00;
endmodule

// ==== rstart_gen.sv ====
// repeated start sequencer with status, buffer and control lock
// assumes open-drain pads with pull-ups; other events flagged on BUS_BUSY
`timescale 1ns/10ps
module rstart_gen (
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	input  wire logic       SCL_IN,
	input  wire logic       SDA_IN,
	output logic            SCL_OUT,
	output logic            SCL_OE,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	input  wire logic [6:0] RATE_RELOAD,
	input  wire logic       CTRL_WR,
	input  wire logic [7:0] CTRL_WDATA,
	output logic      [7:0] CTRL,
	input  wire logic       BUS_BUSY,
	input  wire logic       BUF_WR,
	input  wire logic [7:0] BUF_WDATA,
	output logic      [7:0] BUF,
	input  wire logic       WRITE_COLLISION_FLAG_CLR,
	output logic            WRITE_COLLISION_FLAG,
	input  wire logic       EVENT_CLR,
	output logic            EVENT_FLAG,
	input  wire logic       START_CLR,
	output logic            START_SEEN,
	input  wire logic       BCOL_CLR,
	output logic            BUS_COLLISION,
	output logic            SEQ_ACTIVE
);
	rstart_pkg::rs_state_t  state;
	rstart_pkg::bus_lines_t raw;
	rstart_pkg::bus_lines_t lines;
	logic                   prev_scl;
	logic                   prev_sda;
	logic                   drive_scl;
	logic                   drive_sda;
	logic                   brg_load;
	logic                   brg_run;
	logic [6:0]             brg_value;
	logic                   brg_done;
	logic                   busy;
	logic                   start_det;
	logic                   scl_rise;
	logic                   col_data;
	logic                   col_clock;
	logic                   finish;

	assign raw.scl = SCL_IN;
	assign raw.sda = SDA_IN;

	rstart_sync u_sync (
		.clk (SYS_CLK),
		.rst (RST),
		.d   (raw),
		.q   (lines)
	);

	rstart_brg u_brg (
		.clk   (SYS_CLK),
		.rst   (RST),
		.load  (brg_load),
		.value (brg_value),
		.run   (brg_run),
		.done  (brg_done)
	);

	assign busy      = state != rstart_pkg::ST_IDLE;
	assign start_det = prev_sda && !lines.sda && lines.scl && prev_scl;
	assign scl_rise  = !prev_scl && lines.scl;
	assign col_data  = state == rstart_pkg::ST_SCL_REL && scl_rise && !lines.sda;
	assign col_clock = (state == rstart_pkg::ST_HIGH) && prev_scl && !lines.scl;
	assign finish    = state == rstart_pkg::ST_SDA_LOW && brg_done;

	// bus pin drive: only low or released
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
	assign SCL_OE  = drive_scl;
	assign SDA_OE  = drive_sda;
	assign SEQ_ACTIVE = busy;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			prev_scl <= 1'b1;
			prev_sda <= 1'b1;
		end else begin
			prev_scl <= lines.scl;
			prev_sda <= lines.sda;
		end
	end

	// generator load and run controls
	always_comb begin
		brg_load  = 1'b0;
		brg_value = RATE_RELOAD;
		brg_run   = 1'b0;
		case (state)
			rstart_pkg::ST_SCL_LOW: begin
				brg_load  = !lines.scl;
				brg_value = {1'b0, RATE_RELOAD[rstart_pkg::LOW_RATE_W-1:0]};
			end
			rstart_pkg::ST_SDA_REL: brg_run = 1'b1;
			rstart_pkg::ST_SCL_REL: begin
				brg_load = lines.scl;
			end
			rstart_pkg::ST_HIGH: begin
				brg_run  = 1'b1;
				brg_load = brg_done && lines.scl && lines.sda;
			end
			rstart_pkg::ST_SDA_LOW: brg_run = 1'b1;
			default: begin
				brg_run = 1'b0;
			end
		endcase
	end

	// sequencer
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state     <= rstart_pkg::ST_IDLE;
			drive_scl <= 1'b0;
			drive_sda <= 1'b0;
		end else if (col_data || col_clock) begin
			state     <= rstart_pkg::ST_IDLE;
			drive_scl <= 1'b0;
			drive_sda <= 1'b0;
		end else begin
			case (state)
				rstart_pkg::ST_IDLE: begin
					if (CTRL_WR && CTRL_WDATA[rstart_pkg::RESTART_BIT] && !BUS_BUSY) begin
						state     <= rstart_pkg::ST_SCL_LOW;
						drive_scl <= 1'b1;
					end
				end
				rstart_pkg::ST_SCL_LOW: begin
					if (!lines.scl) begin
						state     <= rstart_pkg::ST_SDA_REL;
						drive_sda <= 1'b0;
					end
				end
				rstart_pkg::ST_SDA_REL: begin
					if (brg_done && lines.sda) begin
						state     <= rstart_pkg::ST_SCL_REL;
						drive_scl <= 1'b0;
					end
				end
				rstart_pkg::ST_SCL_REL: begin
					if (lines.scl) begin
						state <= rstart_pkg::ST_HIGH;
					end
				end
				rstart_pkg::ST_HIGH: begin
					if (brg_done && lines.scl && lines.sda) begin
						state     <= rstart_pkg::ST_SDA_LOW;
						drive_sda <= 1'b1;
					end
				end
				rstart_pkg::ST_SDA_LOW: begin
					if (brg_done) begin
						state <= rstart_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= rstart_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// control register with restart bit and lock
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CTRL <= rstart_pkg::CTRL_RESET;
		end else begin
			if (CTRL_WR) begin
				CTRL[7:rstart_pkg::CTRL_LOCK] <= CTRL_WDATA[7:rstart_pkg::CTRL_LOCK];
				if (!busy && !BUS_BUSY) begin
					CTRL[rstart_pkg::CTRL_LOCK-1:0] <= CTRL_WDATA[rstart_pkg::CTRL_LOCK-1:0];
				end else if (!busy) begin
					CTRL[rstart_pkg::CTRL_LOCK-1:0] <= CTRL_WDATA[rstart_pkg::CTRL_LOCK-1:0]
						& 5'h1D;
				end
			end
			if (finish || col_data || col_clock) begin
				CTRL[rstart_pkg::RESTART_BIT] <= 1'b0;
			end
		end
	end

	// serial buffer and write collision
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			BUF  <= rstart_pkg::BUF_RESET;
			WRITE_COLLISION_FLAG <= 1'b0;
		end else begin
			if (BUF_WR && !busy) begin
				BUF <= BUF_WDATA;
			end
			if (BUF_WR && busy) begin
				WRITE_COLLISION_FLAG <= 1'b1;
			end else if (WRITE_COLLISION_FLAG_CLR) begin
				WRITE_COLLISION_FLAG <= 1'b0;
			end
		end
	end

	// status flags: set wins over clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			EVENT_FLAG    <= 1'b0;
			START_SEEN    <= 1'b0;
			BUS_COLLISION <= 1'b0;
		end else begin
			if (finish) begin
				EVENT_FLAG <= 1'b1;
			end else if (EVENT_CLR) begin
				EVENT_FLAG <= 1'b0;
			end
			if (start_det) begin
				START_SEEN <= 1'b1;
			end else if (START_CLR) begin
				START_SEEN <= 1'b0;
			end
			if (col_data || col_clock) begin
				BUS_COLLISION <= 1'b1;
			end else if (BCOL_CLR) begin
				BUS_COLLISION <= 1'b0;
			end
		end
	end

	// relies on the shifter outside; buffer is free once idle

	property p_start_drive;
		@(posedge SYS_CLK) disable iff (RST)
		(state == rstart_pkg::ST_IDLE && CTRL_WR && CTRL_WDATA[1] && !BUS_BUSY
			&& !col_data && !col_clock) |=> SCL_OE;
	endproperty
	a_start_drive: assert property (p_start_drive) else $error("clock not pulled low");

	property p_ignore_busy;
		@(posedge SYS_CLK) disable iff (RST)
		(state == rstart_pkg::ST_IDLE && BUS_BUSY) |=> state == rstart_pkg::ST_IDLE;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("request taken while busy");

	property p_low_load;
		@(posedge SYS_CLK) disable iff (RST)
		brg_load && state == rstart_pkg::ST_SCL_LOW |-> brg_value[6] == 1'b0;
	endproperty
	a_low_load: assert property (p_low_load) else $error("wrong low reload width");

	property p_sda_released;
		@(posedge SYS_CLK) disable iff (RST)
		state == rstart_pkg::ST_SDA_REL |-> !SDA_OE && SCL_OE;
	endproperty
	a_sda_released: assert property (p_sda_released) else $error("data not released");

	property p_scl_release;
		@(posedge SYS_CLK) disable iff (RST)
		(state == rstart_pkg::ST_SDA_REL && brg_done && lines.sda) |=> !SCL_OE;
	endproperty
	a_scl_release: assert property (p_scl_release) else $error("clock not released");

	property p_high_load;
		@(posedge SYS_CLK) disable iff (RST)
		(state == rstart_pkg::ST_SCL_REL && lines.scl) |-> brg_load && brg_value == RATE_RELOAD;
	endproperty
	a_high_load: assert property (p_high_load) else $error("no full reload");

	property p_sda_low_hold;
		@(posedge SYS_CLK) disable iff (RST)
		state == rstart_pkg::ST_SDA_LOW |-> SDA_OE && !SCL_OE;
	endproperty
	a_sda_low_hold: assert property (p_sda_low_hold) else $error("start edge wrong");

	property p_high_hold;
		@(posedge SYS_CLK) disable iff (RST)
		state == rstart_pkg::ST_HIGH |-> !SDA_OE && !SCL_OE;
	endproperty
	a_high_hold: assert property (p_high_hold) else $error("lines not released");

	property p_low_interval;
		@(posedge SYS_CLK) disable iff (RST)
		($rose(state == rstart_pkg::ST_SDA_LOW) && RATE_RELOAD != 7'h00) |-> !brg_done;
	endproperty
	a_low_interval: assert property (p_low_interval) else $error("start edge too short");

	property p_finish;
		@(posedge SYS_CLK) disable iff (RST)
		finish |=> !CTRL[1] && EVENT_FLAG && SDA_OE;
	endproperty
	a_finish: assert property (p_finish) else $error("end of sequence wrong");

	property p_event_cause;
		@(posedge SYS_CLK) disable iff (RST)
		$rose(EVENT_FLAG) |-> $past(finish);
	endproperty
	a_event_cause: assert property (p_event_cause) else $error("event flag early");

	property p_write_collision_flag;
		@(posedge SYS_CLK) disable iff (RST)
		(BUF_WR && busy) |=> WRITE_COLLISION_FLAG && BUF == $past(BUF);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("buffer write not blocked");

	property p_lock;
		@(posedge SYS_CLK) disable iff (RST)
		(busy && !finish && !col_data && !col_clock) |=> CTRL[4:0] == $past(CTRL[4:0]);
	endproperty
	a_lock: assert property (p_lock) else $error("control bits changed");

	property p_start_seen;
		@(posedge SYS_CLK) disable iff (RST)
		start_det |=> START_SEEN;
	endproperty
	a_start_seen: assert property (p_start_seen) else $error("start not flagged");

	property p_collision;
		@(posedge SYS_CLK) disable iff (RST)
		(col_data || col_clock) |=> BUS_COLLISION && state == rstart_pkg::ST_IDLE;
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged");

	c_finish: cover property (@(posedge SYS_CLK) disable iff (RST) finish);
	c_collision: cover property (@(posedge SYS_CLK) disable iff (RST) col_data || col_clock);
	c_write_collision_flag: cover property (@(posedge SYS_CLK) disable iff (RST) BUF_WR && busy);
endmodule

// ==== rstart_pkg.sv ====
// constants, types and state names for the repeated start generator
// assumes one 40 MHz clock and open-drain bus pads outside the design
// Notes on behaviour
// - restart request while idle pulls clock low
// - clock seen low loads six-bit reload
// - data released for one generator interval
// - timeout with data high releases clock
// - clock seen high loads seven-bit reload
// - both lines high for one interval
// - data low one interval, clock high
// - request self-clears, no reload, data held low
// - start-seen flag on detected start condition
// - event flag only after generator timeout
// - request ignored while other event busy
// - collision if data low at clock rise
// - collision if clock falls before data low
// - buffer write during sequence sets collision
// - low five control bits locked during sequence
package rstart_pkg;
	localparam int RATE_W     = 7;
	localparam int LOW_RATE_W = 6;
	localparam int CTRL_LOCK  = 5;
	localparam int RESTART_BIT = 1;
	localparam logic [RATE_W-1:0] RATE_RESET = 7'h00;
	localparam logic [7:0] BUF_RESET  = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SCL_LOW,
		ST_SDA_REL,
		ST_SCL_REL,
		ST_HIGH,
		ST_SDA_LOW
	} rs_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;
endpackage

// ==== rstart_sync.sv ====
// two-flip-flop synchroniser for the bus lines
// assumes the pad input levels are asynchronous to the clock
`timescale 1ns/10ps
module rstart_sync (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire rstart_pkg::bus_lines_t d,
	output rstart_pkg::bus_lines_t     q
);
	rstart_pkg::bus_lines_t meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= 2'h3;
			q    <= 2'h3;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the repeated start generator
// assumes bus_model as far side and a 40 MHz clock
`timescale 1ns/10ps
module tb_top;
	logic       clk, rst, scl, sda, scl_out, scl_oe, sda_out, sda_oe;
	logic       ctrl_wr, buf_wr, busy, write_collision_flag_clr, write_collision_flag, ev_clr, ev;
	logic       st_clr, st_seen, bc_clr, bcol, active, hold_scl, hold_sda;
	logic [6:0] rate;
	logic [7:0] ctrl_wd, ctrl, buf_wd, buf_q;
	int         error_cnt, comparisons, cyc, n;

	bus_model i_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_scl(hold_scl),
		.hold_sda(hold_sda), .scl(scl), .sda(sda));
	rstart_gen i_dut (.SYS_CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
		.SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.RATE_RELOAD(rate), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wd), .CTRL(ctrl),
		.BUS_BUSY(busy), .BUF_WR(buf_wr), .BUF_WDATA(buf_wd), .BUF(buf_q),
		.WRITE_COLLISION_FLAG_CLR(write_collision_flag_clr), .WRITE_COLLISION_FLAG(write_collision_flag), .EVENT_CLR(ev_clr), .EVENT_FLAG(ev),
		.START_CLR(st_clr), .START_SEEN(st_seen), .BCOL_CLR(bc_clr),
		.BUS_COLLISION(bcol), .SEQ_ACTIVE(active));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return scl_oe;
			1: return sda_oe;
			2: return ev;
			default: return bcol;
		endcase
	endfunction

	// bounded wait, n holds the cycles spent
	task automatic wait_until(input int k, input logic v);
		n = 0;
		while (pick(k) !== v && n < 400) begin
			tick(1);
			n++;
		end
	endtask

	task automatic wr_ctrl(input logic [7:0] d);
		ctrl_wd = d;
		ctrl_wr = 1'h1;
		tick(1);
		ctrl_wr = 1'h0;
	endtask

	task automatic wr_buf(input logic [7:0] d);
		buf_wd = d;
		buf_wr = 1'h1;
		tick(1);
		buf_wr = 1'h0;
	endtask

	task automatic clr_all;
		{write_collision_flag_clr, ev_clr, st_clr, bc_clr} = 4'hF;
		tick(1);
		{write_collision_flag_clr, ev_clr, st_clr, bc_clr} = 4'h0;
		tick(1);
	endtask

	task automatic t_reset;
		check("ctrl", ctrl, 8'h00);
		check("buf", buf_q, 8'h00);
		check("outs", {scl_oe, sda_oe, write_collision_flag, ev, st_seen, bcol, active}, 8'h00);
	endtask

	// full sequence with interval lengths from 7'h43
	task automatic t_normal;
		clr_all();
		wr_ctrl(8'h02);
		tick(1);
		check("scl_oe", scl_oe, 8'h01);
		check("sda_oe", sda_oe, 8'h00);
		check("outs", {scl_out, sda_out}, 8'h00);
		wait_until(0, 1'h0);
		check("t_low", n >= 2 && n <= 12, 8'h01);
		check("sda_oe", sda_oe, 8'h00);
		wait_until(1, 1'h1);
		check("t_high", n >= 67 && n <= 75, 8'h01);
		check("scl_oe", scl_oe, 8'h00);
		check("ev", ev, 8'h00);
		wait_until(2, 1'h1);
		check("t_start", n >= 67 && n <= 75, 8'h01);
		check("ctrl", ctrl, 8'h00);
		check("sda_oe", sda_oe, 8'h01);
		check("st_seen", st_seen, 8'h01);
		check("active", active, 8'h00);
	endtask

	task automatic t_lock;
		clr_all();
		wr_ctrl(8'h02);
		tick(2);
		wr_buf(8'h5A);
		tick(1);
		check("buf", buf_q, 8'h00);
		check("write_collision_flag", write_collision_flag, 8'h01);
		wr_ctrl(8'hE0);
		tick(1);
		check("ctrl", ctrl, 8'hE2);
		wait_until(2, 1'h1);
		check("ctrl", ctrl, 8'hE0);
		clr_all();
		wr_buf(8'h5A);
		tick(1);
		check("buf", buf_q, 8'h5A);
		check("write_collision_flag", write_collision_flag, 8'h00);
		wr_buf(8'hA5);
		tick(1);
		check("buf", buf_q, 8'hA5);
		wr_ctrl(8'h00);
	endtask

	task automatic t_busy;
		busy = 1'h1;
		wr_ctrl(8'h02);
		tick(3);
		check("ctrl", ctrl, 8'h00);
		check("scl_oe", scl_oe, 8'h00);
		busy = 1'h0;
	endtask

	// far side stretches clock, then data is low at clock rise
	task automatic t_col_rise;
		clr_all();
		wr_ctrl(8'h02);
		hold_scl = 1'h1;
		wait_until(0, 1'h0);
		hold_sda = 1'h1;
		tick(4);
		hold_scl = 1'h0;
		wait_until(3, 1'h1);
		check("col_rise", n <= 10, 8'h01);
		check("ctrl", ctrl, 8'h00);
		check("oe", {scl_oe, sda_oe}, 8'h00);
		hold_sda = 1'h0;
		tick(3);
		clr_all();
		check("bcol", bcol, 8'h00);
	endtask

	// far side pulls clock low inside the high interval
	task automatic t_col_low;
		clr_all();
		wr_ctrl(8'h02);
		wait_until(0, 1'h0);
		tick(8);
		hold_scl = 1'h1;
		wait_until(3, 1'h1);
		check("col_low", n <= 10, 8'h01);
		check("sda_oe", sda_oe, 8'h00);
		check("ctrl", ctrl, 8'h00);
		hold_scl = 1'h0;
		tick(4);
		clr_all();
	endtask

	initial begin
		{rst, ctrl_wr, buf_wr, busy, write_collision_flag_clr, ev_clr} = 6'h20;
		{st_clr, bc_clr, hold_scl, hold_sda} = 4'h0;
		{ctrl_wd, buf_wd} = 16'h0000;
		rate = 7'h43;
		repeat (6) @(posedge clk);
		#2;
		rst = 1'h0;
		t_reset();
		t_normal();
		t_lock();
		t_busy();
		t_col_rise();
		t_col_low();
		print_verdict();
	end
endmodule
